// >>> logic/bqe_pkg.sv
// Constants, register map and carrier types of the breakpoint event qualifier.
// Assumes one 40 MHz clock shared with the processor bus and a synchronous reset.
`default_nettype none
package bqe_pkg;

	// ****************
	// Register offsets
	// ****************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_MSETUP = 8'h04;
	localparam logic [7:0] A_MADDR1 = 8'h08;
	localparam logic [7:0] A_MADDR2 = 8'h0C;
	localparam logic [7:0] A_MWORD = 8'h10;
	localparam logic [7:0] A_MMASK = 8'h14;
	localparam logic [7:0] A_MPROBE = 8'h18;
	localparam logic [7:0] A_ISETUP = 8'h1C;
	localparam logic [7:0] A_IADDR1 = 8'h20;
	localparam logic [7:0] A_IADDR2 = 8'h24;
	localparam logic [7:0] A_IPROBE = 8'h28;
	localparam logic [7:0] A_AMASK = 8'h2C;
	localparam logic [7:0] A_EVCNT = 8'h30;
	localparam logic [7:0] A_DLYCNT = 8'h34;
	localparam logic [7:0] A_TRCNT = 8'h38;
	localparam logic [7:0] A_XBITS = 8'h3C;
	localparam logic [7:0] A_XADDR = 8'h40;
	localparam logic [7:0] A_STATUS = 8'h44;
	localparam logic [7:0] A_EVLEFT = 8'h48;
	localparam logic [7:0] A_DLYLEFT = 8'h4C;
	localparam logic [7:0] A_WPTR = 8'h50;
	localparam logic [7:0] A_TIDX = 8'h54;
	localparam logic [7:0] A_TDATA = 8'h58;

	// ****************
	// Field positions
	// ****************
	localparam int CTRL_RUN = 0;
	localparam int CTRL_TREN = 1;
	localparam int CTRL_HFULL = 2;
	localparam int MS_QUAL = 0;
	localparam int MS_WIN = 3;
	localparam int IS_QUAL = 0;
	localparam int IS_WIN = 1;
	localparam int PB_BYTE = 0;
	localparam int PB_MASK = 8;
	localparam int ST_HALT = 0;
	localparam int ST_DELAY = 1;
	localparam int ST_TSTOP = 2;
	localparam int ST_WRAP = 3;
	localparam int ST_EVDONE = 4;

	// ****************
	// Widths, codes and reset values
	// ****************
	localparam int EV_W = 15;
	localparam int DLY_W = 11;
	localparam int TR_AW = 11;
	localparam int TR_DEPTH = 2048;
	localparam logic [3:0] XBITS_MAX = 4'h8;
	localparam logic [15:0] AMASK_RST = 16'hFFFF;
	localparam logic [15:0] IO_LSB_OFF = 16'hFFFE;
	localparam logic [2:0] MQ_OFF = 3'h0;
	localparam logic [2:0] MQ_ANY = 3'h1;
	localparam logic [2:0] MQ_RDF = 3'h2;
	localparam logic [2:0] MQ_WR = 3'h3;
	localparam logic [2:0] MQ_FETCH = 3'h4;

	typedef enum logic [2:0] {PH_IDLE, PH_EVENTS, PH_DELAY, PH_STOPPING, PH_HALTED} bqe_phase_e;

	// One observed bus cycle of the emulated processor.
	typedef struct packed {
		logic valid;
		logic mem_rd;
		logic mem_wr;
		logic fetch;
		logic io;
		logic [15:0] addr;
		logic [15:0] data;
		logic [7:0] probe;
	} bqe_cycle_s;

	// Address window and probe-cable match settings of one cycle class.
	typedef struct packed {
		logic [2:0] qual;
		logic win;
		logic [15:0] a1;
		logic [15:0] a2;
		logic [7:0] pbyte;
		logic [7:0] pmask;
	} bqe_match_s;

	typedef struct packed {
		bqe_match_s mem;
		bqe_match_s io;
		logic [15:0] mword;
		logic [15:0] mmask;
		logic [15:0] amask;
		logic [EV_W-1:0] evcnt;
		logic [DLY_W-1:0] dlycnt;
		logic [TR_AW-1:0] trcnt;
		logic [3:0] xbits;
		logic [7:0] xaddr;
		logic tren;
		logic hfull;
		bqe_phase_e phase;
		logic [EV_W-1:0] evleft;
		logic [DLY_W-1:0] dlyleft;
		logic [TR_AW-1:0] wptr;
		logic [TR_AW-1:0] nsamp;
		logic [TR_AW-1:0] tidx;
		logic tstop;
		logic wrap;
		logic hit;
		logic evpulse;
		logic halt;
		logic rec;
		logic [31:0] rdata;
	} bqe_state_s;

endpackage
`default_nettype wire

// >>> logic/bqe_breakpoint_qualifier.sv
// Breakpoint event qualifier: match, event count, delay count, halt and trace buffer.
// Assumes bus cycle fields, the instruction boundary and the trace sample qualifier
// arrive synchronous to core_clk_in from the processor probe and the trace block.
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module bqe_breakpoint_qualifier (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire bqe_pkg::bqe_cycle_s cycle_in,
	input wire logic instr_end_in,
	input wire logic trace_sample_in,
	output logic halt_out,
	output logic event_out,
	output logic trace_record_out
);
	import bqe_pkg::*;

	// ****************
	// State
	// ****************
	bqe_state_s st_ff;
	bqe_state_s nxt_st;
	logic [31:0] trace_mem [TR_DEPTH];
	logic mem_hit;
	logic io_hit;
	logic mem_qok;
	logic take;

	// ****************
	// Match helpers
	// ****************
	function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] a1,
		input logic [15:0] a2, input logic win, input logic [15:0] m);
		logic rev;
		logic [15:0] am;
		logic [15:0] m1;
		logic [15:0] m2;
		rev = a2 < a1;
		am = a & m;
		m1 = a1 & m;
		m2 = a2 & m;
		if (!win)
		begin
			addr_hit = (am == m1) || (am == m2);
		end
		else if (rev)
		begin
			addr_hit = (am < m2) || (am > m1);
		end
		else
		begin
			addr_hit = (am >= m1) && (am <= m2);
		end
	endfunction

	// Low probe bits are data, the top xbits bits carry extended address.
	function automatic logic probe_hit(input logic [7:0] p, input logic [7:0] cb,
		input logic [7:0] cm, input logic [7:0] xa, input logic [3:0] n);
		logic [7:0] dfield;
		logic dok;
		logic xok;
		dfield = 8'hFF >> n;
		dok = (((p ^ cb) & cm & dfield) == 8'h00);
		xok = (((p ^ xa) & ~dfield) == 8'h00);
		probe_hit = dok && xok;
	endfunction

	// ****************
	// Qualification
	// ****************
	always_comb
	begin
		case (st_ff.mem.qual)
			MQ_ANY: mem_qok = cycle_in.mem_rd | cycle_in.mem_wr | cycle_in.fetch;
			MQ_RDF: mem_qok = cycle_in.mem_rd | cycle_in.fetch;
			MQ_WR: mem_qok = cycle_in.mem_wr;
			MQ_FETCH: mem_qok = cycle_in.fetch;
			default: mem_qok = 1'b0;
		endcase
	end

	assign mem_hit = cycle_in.valid && !cycle_in.io && mem_qok
		&& addr_hit(cycle_in.addr, st_ff.mem.a1, st_ff.mem.a2, st_ff.mem.win, st_ff.amask)
		&& (((cycle_in.data ^ st_ff.mword) & st_ff.mmask) == 16'h0000)
		&& probe_hit(cycle_in.probe, st_ff.mem.pbyte, st_ff.mem.pmask,
			st_ff.xaddr, st_ff.xbits);

	assign io_hit = cycle_in.valid && cycle_in.io && st_ff.io.qual[0]
		&& addr_hit(cycle_in.addr, st_ff.io.a1, st_ff.io.a2, st_ff.io.win,
			st_ff.amask & IO_LSB_OFF)
		&& probe_hit(cycle_in.probe, st_ff.io.pbyte, st_ff.io.pmask,
			st_ff.xaddr, st_ff.xbits);

	assign take = trace_sample_in && st_ff.tren && !st_ff.tstop
		&& (st_ff.phase != PH_IDLE) && (st_ff.phase != PH_HALTED);

	// ****************
	// Next state
	// ****************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.evpulse = 1'b0;
		nxt_st.rdata = 32'h0000_0000;
		nxt_st.hit = mem_hit | io_hit;

		// The registered hit counts, so the match acts one clock late.
		if ((st_ff.phase == PH_EVENTS) && st_ff.hit)
		begin
			nxt_st.evpulse = 1'b1;
			if (st_ff.evleft <= 15'h0001)
			begin
				nxt_st.evleft = '0;
				nxt_st.phase = (st_ff.dlycnt == 11'h000) ? PH_STOPPING : PH_DELAY;
			end
			else
			begin
				nxt_st.evleft = st_ff.evleft - 15'h0001;
			end
		end

		if (take)
		begin
			nxt_st.nsamp = st_ff.nsamp + 11'h001;
			nxt_st.wptr = st_ff.wptr + 11'h001;
			if ((st_ff.trcnt == 11'h000) && (st_ff.wptr == 11'h7FF))
			begin
				nxt_st.wrap = 1'b1;
			end
			if (st_ff.phase == PH_DELAY)
			begin
				nxt_st.dlyleft = st_ff.dlyleft - 11'h001;
				if (st_ff.dlyleft == 11'h001)
				begin
					nxt_st.phase = PH_STOPPING;
				end
			end
			if ((st_ff.trcnt != 11'h000) && (nxt_st.nsamp == st_ff.trcnt))
			begin
				nxt_st.tstop = 1'b1;
				if (st_ff.hfull)
				begin
					nxt_st.phase = PH_STOPPING;
				end
			end
		end

		if ((st_ff.phase == PH_STOPPING) && instr_end_in)
		begin
			nxt_st.phase = PH_HALTED;
			nxt_st.tstop = 1'b1;
		end
		nxt_st.halt = (nxt_st.phase == PH_HALTED);

		// ****************
		// Register writes
		// ****************
		if (reg_wr_in)
		begin
			if (reg_addr_in == A_CTRL)
			begin
				nxt_st.tren = reg_wdata_in[CTRL_TREN];
				nxt_st.hfull = reg_wdata_in[CTRL_HFULL];
				// Run re-arms counters and clears earlier history.
				if (reg_wdata_in[CTRL_RUN])
				begin
					nxt_st.phase = PH_EVENTS;
					nxt_st.evleft = st_ff.evcnt;
					nxt_st.dlyleft = st_ff.dlycnt;
					nxt_st.wptr = '0;
					nxt_st.nsamp = '0;
					nxt_st.tstop = 1'b0;
					nxt_st.wrap = 1'b0;
					nxt_st.hit = 1'b0;
					nxt_st.halt = 1'b0;
				end
			end
			else if (reg_addr_in == A_MSETUP)
			begin
				nxt_st.mem.qual = reg_wdata_in[MS_QUAL +: 3];
				nxt_st.mem.win = reg_wdata_in[MS_WIN];
			end
			else if (reg_addr_in == A_MADDR1)
			begin
				nxt_st.mem.a1 = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_MADDR2)
			begin
				nxt_st.mem.a2 = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_MWORD)
			begin
				nxt_st.mword = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_MMASK)
			begin
				nxt_st.mmask = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_MPROBE)
			begin
				nxt_st.mem.pbyte = reg_wdata_in[PB_BYTE +: 8];
				nxt_st.mem.pmask = reg_wdata_in[PB_MASK +: 8];
			end
			else if (reg_addr_in == A_ISETUP)
			begin
				nxt_st.io.qual = {2'b00, reg_wdata_in[IS_QUAL]};
				nxt_st.io.win = reg_wdata_in[IS_WIN];
			end
			else if (reg_addr_in == A_IADDR1)
			begin
				nxt_st.io.a1 = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_IADDR2)
			begin
				nxt_st.io.a2 = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_IPROBE)
			begin
				nxt_st.io.pbyte = reg_wdata_in[PB_BYTE +: 8];
				nxt_st.io.pmask = reg_wdata_in[PB_MASK +: 8];
			end
			else if (reg_addr_in == A_AMASK)
			begin
				nxt_st.amask = reg_wdata_in[15:0];
			end
			else if (reg_addr_in == A_EVCNT)
			begin
				nxt_st.evcnt = reg_wdata_in[EV_W-1:0];
			end
			else if (reg_addr_in == A_DLYCNT)
			begin
				nxt_st.dlycnt = reg_wdata_in[DLY_W-1:0];
			end
			else if (reg_addr_in == A_TRCNT)
			begin
				nxt_st.trcnt = reg_wdata_in[TR_AW-1:0];
			end
			else if (reg_addr_in == A_XBITS)
			begin
				nxt_st.xbits = (reg_wdata_in[3:0] > XBITS_MAX) ? XBITS_MAX
					: reg_wdata_in[3:0];
			end
			else if (reg_addr_in == A_XADDR)
			begin
				nxt_st.xaddr = reg_wdata_in[7:0];
			end
			else if (reg_addr_in == A_TIDX)
			begin
				nxt_st.tidx = reg_wdata_in[TR_AW-1:0];
			end
		end

		// Recording state is registered so the output comes from a flip-flop.
		nxt_st.rec = nxt_st.tren && !nxt_st.tstop && (nxt_st.phase != PH_IDLE)
			&& (nxt_st.phase != PH_HALTED);

		// ****************
		// Register reads
		// ****************
		if (reg_rd_in)
		begin
			if (reg_addr_in == A_CTRL)
			begin
				nxt_st.rdata = {29'h0, st_ff.hfull, st_ff.tren, 1'b0};
			end
			else if (reg_addr_in == A_MSETUP)
			begin
				nxt_st.rdata = {28'h0, st_ff.mem.win, st_ff.mem.qual};
			end
			else if (reg_addr_in == A_MADDR1)
			begin
				nxt_st.rdata = {16'h0, st_ff.mem.a1};
			end
			else if (reg_addr_in == A_MADDR2)
			begin
				nxt_st.rdata = {16'h0, st_ff.mem.a2};
			end
			else if (reg_addr_in == A_MWORD)
			begin
				nxt_st.rdata = {16'h0, st_ff.mword};
			end
			else if (reg_addr_in == A_MMASK)
			begin
				nxt_st.rdata = {16'h0, st_ff.mmask};
			end
			else if (reg_addr_in == A_MPROBE)
			begin
				nxt_st.rdata = {16'h0, st_ff.mem.pmask, st_ff.mem.pbyte};
			end
			else if (reg_addr_in == A_ISETUP)
			begin
				nxt_st.rdata = {30'h0, st_ff.io.win, st_ff.io.qual[0]};
			end
			else if (reg_addr_in == A_IADDR1)
			begin
				nxt_st.rdata = {16'h0, st_ff.io.a1};
			end
			else if (reg_addr_in == A_IADDR2)
			begin
				nxt_st.rdata = {16'h0, st_ff.io.a2};
			end
			else if (reg_addr_in == A_IPROBE)
			begin
				nxt_st.rdata = {16'h0, st_ff.io.pmask, st_ff.io.pbyte};
			end
			else if (reg_addr_in == A_AMASK)
			begin
				nxt_st.rdata = {16'h0, st_ff.amask};
			end
			else if (reg_addr_in == A_EVCNT)
			begin
				nxt_st.rdata = {17'h0, st_ff.evcnt};
			end
			else if (reg_addr_in == A_DLYCNT)
			begin
				nxt_st.rdata = {21'h0, st_ff.dlycnt};
			end
			else if (reg_addr_in == A_TRCNT)
			begin
				nxt_st.rdata = {21'h0, st_ff.trcnt};
			end
			else if (reg_addr_in == A_XBITS)
			begin
				nxt_st.rdata = {28'h0, st_ff.xbits};
			end
			else if (reg_addr_in == A_XADDR)
			begin
				nxt_st.rdata = {24'h0, st_ff.xaddr};
			end
			else if (reg_addr_in == A_STATUS)
			begin
				nxt_st.rdata = {27'h0, (st_ff.phase == PH_DELAY) || (st_ff.phase
					== PH_STOPPING), st_ff.wrap, st_ff.tstop,
					st_ff.phase == PH_DELAY, st_ff.halt};
				nxt_st.rdata[ST_EVDONE] = (st_ff.phase != PH_EVENTS)
					&& (st_ff.phase != PH_IDLE);
				nxt_st.rdata[ST_DELAY] = (st_ff.phase == PH_DELAY);
			end
			else if (reg_addr_in == A_EVLEFT)
			begin
				nxt_st.rdata = {17'h0, st_ff.evleft};
			end
			else if (reg_addr_in == A_DLYLEFT)
			begin
				nxt_st.rdata = {21'h0, st_ff.dlyleft};
			end
			else if (reg_addr_in == A_WPTR)
			begin
				nxt_st.rdata = {21'h0, st_ff.wptr};
			end
			else if (reg_addr_in == A_TIDX)
			begin
				nxt_st.rdata = {21'h0, st_ff.tidx};
			end
			else if (reg_addr_in == A_TDATA)
			begin
				nxt_st.rdata = trace_mem[st_ff.tidx];
			end
		end
	end

	// ****************
	// Registers and trace buffer
	// ****************
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			st_ff <= '0;
			st_ff.amask <= AMASK_RST;
			st_ff.phase <= PH_IDLE;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	always_ff @(posedge core_clk_in)
	begin
		if (take)
		begin
			trace_mem[st_ff.wptr] <= {cycle_in.addr, cycle_in.data};
		end
	end

	assign reg_rdata_out = st_ff.rdata;
	assign halt_out = st_ff.halt;
	assign event_out = st_ff.evpulse;
	assign trace_record_out = st_ff.rec;

endmodule // bqe_breakpoint_qualifier

`default_nettype wire

// >>> sim/bqe_breakpoint_checker.sv
// Port-level assertions for the breakpoint event qualifier.
// Assumes it is bound to the qualifier and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module bqe_breakpoint_checker (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire bqe_pkg::bqe_cycle_s cycle_in,
	input wire logic instr_end_in,
	input wire logic trace_sample_in,
	input wire logic halt_out,
	input wire logic event_out,
	input wire logic trace_record_out
);
	import bqe_pkg::*;
	logic run_wr;
	assign run_wr = reg_wr_in && (reg_addr_in == A_CTRL) && reg_wdata_in[CTRL_RUN];
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	event_cause_a: assert property (
		event_out |-> $past(cycle_in.valid, 2) && ($past(cycle_in.io, 2) ||
		$past(cycle_in.mem_rd, 2) || $past(cycle_in.mem_wr, 2) || $past(cycle_in.fetch, 2)))
		else $error("event without a bus cycle");
	evleft_width_a: assert property (
		$past(reg_rd_in) && $past(reg_addr_in) == A_EVLEFT |-> reg_rdata_out[31:EV_W] == '0)
		else $error("event count wider than its field");
	dlyleft_width_a: assert property (
		$past(reg_rd_in) && $past(reg_addr_in) == A_DLYLEFT |-> reg_rdata_out[31:DLY_W] == '0)
		else $error("delay count wider than its field");
	halt_hold_a: assert property (
		halt_out && !run_wr |=> halt_out)
		else $error("halt dropped without a run");
	halt_boundary_a: assert property (
		$rose(halt_out) |-> $past(instr_end_in))
		else $error("halt away from an instruction boundary");
	halt_trace_a: assert property (
		halt_out |-> !trace_record_out)
		else $error("trace still recording while halted");
	halted_quiet_a: assert property (
		halt_out && $past(halt_out) |-> !event_out)
		else $error("event counted while halted");
	run_rearm_a: assert property (
		run_wr |=> !halt_out && trace_record_out == $past(reg_wdata_in[CTRL_TREN]))
		else $error("run did not re-arm");
endmodule // bqe_breakpoint_checker
`default_nettype wire

// >>> sim/bqe_proc_model.sv
// Behavioural model of the emulated processor bus feeding the qualifier.
// Assumes the bench asks for one bus cycle per clock with go high.
`timescale 1ns/100ps
`default_nettype none
module bqe_proc_model (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic samp_in,
	input wire bqe_pkg::bqe_cycle_s next_in,
	input wire logic [3:0] bound_in,
	output bqe_pkg::bqe_cycle_s cycle_out,
	output logic instr_end_out,
	output logic trace_sample_out
);
	import bqe_pkg::*;
	logic [3:0] cnt_ff;
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			cycle_out <= '0;
			cnt_ff <= 4'h0;
			instr_end_out <= 1'b0;
			trace_sample_out <= 1'b0;
		end
		else
		begin
			cycle_out <= next_in;
			// An idle bus clears the control bits and shows the inverse of its last address, data and probe, never a stale copy.
			if (!go_in)
				cycle_out <= {5'h00, ~cycle_out.addr, ~cycle_out.data, ~cycle_out.probe};
			trace_sample_out <= go_in & samp_in;
			cnt_ff <= (cnt_ff == 4'h0) ? bound_in - 4'h1 : cnt_ff - 4'h1;
			instr_end_out <= (cnt_ff == 4'h0);
		end
	end
endmodule // bqe_proc_model
`default_nettype wire

// >>> sim/bqe_breakpoint_qualifier_tb.sv
// Self-checking bench for the breakpoint event qualifier.
// Assumes the processor bus model and the port checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module bqe_breakpoint_qualifier_tb;
	import bqe_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, go, samp, iend, tsamp, halt, evt, trec;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0] bound;
	bqe_cycle_s nxt, cyc;
	int err_count, tests_run;
	bqe_proc_model i_bus (.core_clk_in(clk), .rst_n_in(rst_n), .go_in(go), .samp_in(samp),
		.next_in(nxt), .bound_in(bound), .cycle_out(cyc), .instr_end_out(iend),
		.trace_sample_out(tsamp));
	bqe_breakpoint_qualifier i_dut (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata), .cycle_in(cyc), .instr_end_in(iend),
		.trace_sample_in(tsamp), .halt_out(halt), .event_out(evt), .trace_record_out(trec));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		chk("register", e, v);
	endtask
	// Presents one bus cycle and looks at event_out two edges after it is sampled.
	task automatic bus(input bqe_cycle_s c, input logic s, input logic e);
		nxt <= c;
		go <= 1'b1;
		samp <= s;
		@(posedge clk);
		go <= 1'b0;
		repeat (3) @(posedge clk);
		chk("event_out", {31'h0, e}, {31'h0, evt});
	endtask
	task automatic wait_halt;
		for (int j = 0; j < 20 && halt !== 1'b1; j++)
			@(posedge clk);
		chk("halt_out", 32'h1, {31'h0, halt});
	endtask
	function automatic bqe_cycle_s mk(logic [1:0] k, logic io, logic [15:0] a, d, logic [7:0] p);
		return {1'b1, k == 2'h0 && !io, k == 2'h1 && !io, k == 2'h2 && !io, io, a, d, p};
	endfunction
	function automatic logic q_ok(logic [2:0] q, logic [1:0] k);
		case (q)
			MQ_ANY: return 1'b1;
			MQ_RDF: return k != 2'h1;
			MQ_WR: return k == 2'h1;
			MQ_FETCH: return k == 2'h2;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic in_win(logic [15:0] a, a1, a2, logic w, logic [15:0] m);
		if (!w)
			return ((a & m) == (a1 & m)) || ((a & m) == (a2 & m));
		if (a2 < a1)
			return ((a & m) < (a2 & m)) || ((a & m) > (a1 & m));
		return ((a & m) >= (a1 & m)) && ((a & m) <= (a2 & m));
	endfunction
	function automatic logic [15:0] pick(logic [15:0] a1, a2);
		case ($urandom % 5)
			0: return a1;
			1: return a2;
			2: return a1 - 16'h1;
			3: return a2 + 16'h1;
			default: return 16'($urandom);
		endcase
	endfunction
	initial
	begin
		logic [31:0] v;
		logic [15:0] a1, a2, m, dw, dm, a, d;
		logic [7:0] pb, pm, p, dmask;
		logic [3:0] n, nx;
		logic [2:0] q;
		logic [1:0] k;
		logic w;
		err_count = 0;
		tests_run = 0;
		{rst_n, reg_wr, reg_rd, go, samp} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		nxt = '0;
		bound = 4'h1;
		v = $urandom(18);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_reg(A_AMASK, 32'h0000FFFF);
		chk_reg(8'hFC, 32'h0);
		wr(A_EVCNT, 32'hFFFF);
		wr(A_DLYCNT, 32'hFFF);
		chk_reg(A_EVCNT, 32'h7FFF);
		chk_reg(A_DLYCNT, 32'h7FF);
		for (int i = 0; i < 60; i++)
		begin
			q = 3'(i % 5);
			w = i[2];
			a1 = 16'($urandom) & 16'h3FFE;
			a2 = 16'($urandom) & 16'h3FFE;
			m = i[0] ? 16'hFFFF : 16'h3FFF;
			dw = 16'($urandom);
			dm = i[1] ? 16'hFFFF : 16'hFFF0;
			wr(A_MSETUP, {28'h0, w, q});
			wr(A_MADDR1, {16'h0, a1});
			wr(A_MADDR2, {16'h0, a2});
			wr(A_MWORD, {16'h0, dw});
			wr(A_MMASK, {16'h0, dm});
			wr(A_AMASK, {16'h0, m});
			wr(A_CTRL, 32'h1);
			repeat (4)
			begin
				k = 2'($urandom % 3);
				a = pick(a1, a2);
				d = dw ^ (16'($urandom) & 16'h001F);
				bus(mk(k, 1'b0, a, d, 8'h00), 1'b0, q_ok(q, k) && in_win(a, a1, a2, w, m) &&
					(((d ^ dw) & dm) == 16'h0));
			end
		end
		wr(A_MSETUP, 32'h0);
		wr(A_MMASK, 32'hFFFF);
		wr(A_AMASK, 32'hFFFF);
		wr(A_XADDR, 32'hFF);
		for (int i = 0; i < 40; i++)
		begin
			q = 3'(i % 4 != 0);
			w = i[1];
			a1 = 16'($urandom) & 16'h3FFE;
			a2 = 16'($urandom) & 16'h3FFE;
			pb = 8'($urandom);
			pm = 8'($urandom);
			n = 4'($urandom % 10);
			nx = (n > 4'h8) ? 4'h8 : n;
			dmask = 8'hFF >> nx;
			wr(A_ISETUP, {30'h0, w, q[0]});
			wr(A_IADDR1, {16'h0, a1});
			wr(A_IADDR2, {16'h0, a2});
			wr(A_IPROBE, {16'h0, pm, pb});
			wr(A_XBITS, {28'h0, n});
			chk_reg(A_XBITS, {28'h0, nx});
			wr(A_CTRL, 32'h1);
			repeat (4)
			begin
				a = pick(a1, a2) ^ 16'($urandom % 2);
				p = ($urandom % 2) ? pb : 8'($urandom);
				if ($urandom % 4 != 0)
					p = p | ~dmask;
				bus(mk(2'h0, 1'b1, a, 16'($urandom), p), 1'b0, q[0] &&
					in_win(a, a1, a2, w, IO_LSB_OFF) && (((p ^ pb) & pm & dmask) == 8'h0) &&
					((p | dmask) == 8'hFF));
			end
		end
		wr(A_XBITS, 32'h0);
		wr(A_IPROBE, 32'h0);
		wr(A_ISETUP, 32'h3);
		wr(A_IADDR1, 32'h0);
		wr(A_IADDR2, 32'hFFFF);
		wr(A_MSETUP, {28'h0, 1'b1, MQ_ANY});
		wr(A_MADDR1, 32'h0);
		wr(A_MADDR2, 32'hFFFF);
		wr(A_MMASK, 32'h0);
		wr(A_EVCNT, 32'h3);
		wr(A_DLYCNT, 32'h2);
		bound <= 4'h4;
		wr(A_CTRL, 32'h3);
		bus(mk(2'h0, 1'b0, 16'h0100, 16'h0, 8'h0), 1'b0, 1'b1);
		bus(mk(2'h0, 1'b1, 16'h0040, 16'h0, 8'h0), 1'b0, 1'b1);
		bus(mk(2'h2, 1'b0, 16'h0102, 16'h0, 8'h0), 1'b0, 1'b1);
		chk_reg(A_STATUS, 32'h12);
		chk_reg(A_EVLEFT, 32'h0);
		chk_reg(A_DLYLEFT, 32'h2);
		bus(mk(2'h0, 1'b0, 16'h0104, 16'h0, 8'h0), 1'b1, 1'b0);
		chk("halt_out", 32'h0, {31'h0, halt});
		bus(mk(2'h0, 1'b0, 16'h0106, 16'h0, 8'h0), 1'b1, 1'b0);
		wait_halt();
		rd(A_STATUS, v);
		chk("status", 32'h5, v & 32'h7);
		chk_reg(A_DLYLEFT, 32'h0);
		chk("trace_record_out", 32'h0, {31'h0, trec});
		wr(A_MSETUP, 32'h0);
		wr(A_ISETUP, 32'h0);
		wr(A_TRCNT, 32'h3);
		bound <= 4'h1;
		wr(A_CTRL, 32'h7);
		bus(mk(2'h0, 1'b0, 16'hA5A4, 16'h5A5B, 8'h0), 1'b1, 1'b0);
		bus(mk(2'h1, 1'b0, 16'h1111, 16'h2222, 8'h0), 1'b1, 1'b0);
		bus(mk(2'h2, 1'b0, 16'h3333, 16'h4444, 8'h0), 1'b1, 1'b0);
		wait_halt();
		wr(A_TIDX, 32'h0);
		chk_reg(A_TDATA, 32'hA5A45A5B);
		wr(A_TRCNT, 32'h0);
		wr(A_CTRL, 32'h7);
		nxt <= mk(2'h0, 1'b0, 16'h0200, 16'h0300, 8'h0);
		go <= 1'b1;
		samp <= 1'b1;
		repeat (2050) @(posedge clk);
		go <= 1'b0;
		repeat (4) @(posedge clk);
		chk_reg(A_WPTR, 32'h2);
		chk("halt_out", 32'h0, {31'h0, halt});
		rd(A_STATUS, v);
		chk("wrapped", 32'h1, {31'h0, v[ST_WRAP]});
		tally_and_finish();
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule // bqe_breakpoint_qualifier_tb
bind bqe_breakpoint_qualifier bqe_breakpoint_checker i_chk (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.cycle_in(cycle_in), .instr_end_in(instr_end_in), .trace_sample_in(trace_sample_in),
	.halt_out(halt_out), .event_out(event_out), .trace_record_out(trace_record_out));
`default_nettype wire
